// *** core/srdc_regs.svh ***
`ifndef SRDC_REGS_SVH
`define SRDC_REGS_SVH

`define SRDC_ADDR_ENABLE   10'h2b0
`define SRDC_ADDR_CONFIG   10'h2b1
`define SRDC_ADDR_RESULT   10'h2b2
`define SRDC_ADDR_IRQ_STAT 10'h2b8
`define SRDC_ADDR_IRQ_CLR  10'h2b9
`define SRDC_ADDR_IRQ_EN   10'h2ba

`define SRDC_ENABLE_RST    8'h00
`define SRDC_CONFIG_RST    8'h05
`define SRDC_EN_BIT        0
`define SRDC_AVG_MSB       3
`define SRDC_AVG_LSB       2
`define SRDC_DUR_MSB       1
`define SRDC_DUR_LSB       0
`define SRDC_DONE_BIT      17
`define SRDC_INV_BIT       16
`define SRDC_IRQ_DONE_BIT  0
`define SRDC_IRQ_FAIL_BIT  1

`define SRDC_PERIOD_LIM0   128
`define SRDC_PERIOD_LIM1   1664
`define SRDC_PERIOD_LIM2   7808
`define SRDC_PERIOD_LIM3   32384
`define SRDC_CAL_BASE      384
`define SRDC_CAL_STEPS     19
`define SRDC_CAL_EXP_OFS   2
`define SRDC_WIN_BASE      4
`define SRDC_AVG_BASE_LOG2 2

`endif

// *** core/srdc_pkg.sv ***
package srdc_pkg;
   typedef enum logic [4:0] {
      srdc_idle = 5'h01,
      srdc_seek = 5'h02,
      srdc_run  = 5'h04,
      srdc_done = 5'h08,
      srdc_fail = 5'h10
   } srdc_state_e;
endpackage

// *** core/srdc_pin_sync.sv ***
`timescale 1ns/10ps
module srdc_pin_sync (
   input  wire logic core_clk,   // sample clock
   input  wire logic rst_n,      // synced reset, low active
   input  wire logic ce,         // clock enable
   input  wire logic pin,        // asynchronous pin
   output logic      level       // filtered level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // level moves only once the two later stages agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level  <= 1'b0;
      end else if (ce) begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level <= s2_reg;
         end
      end
   end
endmodule

// *** core/srdc_phase_avg.sv ***
`timescale 1ns/10ps
module srdc_phase_avg #(
   parameter int unsigned PW = 9,   // phase width
   parameter int unsigned NW = 9    // sample count width
) (
   input  wire logic          core_clk,   // sample clock
   input  wire logic          rst_n,      // synced reset, low active
   input  wire logic          ce,         // clock enable
   input  wire logic          clear,      // restart averaging
   input  wire logic          sample,     // take phase this cycle
   input  wire logic [PW-1:0] phase,      // phase sample
   input  wire logic [3:0]    shift,      // log2 of sample count
   output logic      [NW-1:0] count,      // samples taken
   output logic      [PW-1:0] average     // accumulated sum scaled down
);
   localparam int unsigned AW = PW + NW;

   if (PW < 2 || NW < 2) begin : g_chk
      $error("srdc_phase_avg: widths too small");
   end

   logic [AW-1:0] acc_reg;
   wire  [AW-1:0] acc_shifted = acc_reg >> shift;

   assign average = acc_shifted[PW-1:0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= '0;
         count   <= '0;
      end else if (ce) begin
         if (clear) begin
            acc_reg <= '0;
            count   <= '0;
         end else if (sample) begin
            acc_reg <= acc_reg + AW'(phase);
            count   <= count + NW'(1);
         end
      end
   end
endmodule

// *** core/srdc_top.sv ***
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "srdc_regs.svh"
module srdc_top
   import srdc_pkg::*;
#(
   parameter int unsigned CAL_UNIT    = `SRDC_CAL_BASE * `SRDC_CAL_STEPS,
   parameter int unsigned PERIOD_LIM0 = `SRDC_PERIOD_LIM0,
   parameter int unsigned PERIOD_LIM1 = `SRDC_PERIOD_LIM1,
   parameter int unsigned PERIOD_LIM2 = `SRDC_PERIOD_LIM2,
   parameter int unsigned PERIOD_LIM3 = `SRDC_PERIOD_LIM3
) (
   input  wire logic        core_clk,       // sample clock, 40 MHz
   input  wire logic        resetn,         // async reset, low active
   input  wire logic        ce,             // clock enable, freezes state
   input  wire logic [9:0]  addr,           // register address
   input  wire logic [7:0]  wr_data,        // write data
   input  wire logic        wr_strobe,      // write strobe
   input  wire logic        rd_strobe,      // read strobe
   output logic      [23:0] rd_data,        // read data, cycle after strobe
   input  wire logic [16:0] manual_delay,   // manual timing-adjust value
   input  wire logic        sysref_pin,     // incoming sysref
   output logic      [16:0] delay_ctrl,     // sample-clock delay control
   output logic             cal_irq         // level interrupt
);
   if (CAL_UNIT < 1 || CAL_UNIT > 32'h0000ffff || PERIOD_LIM3 > 32'h0000fffe ||
       PERIOD_LIM0 < 1) begin : g_chk
      $error("srdc_top: unsupported timing parameters");
   end

   logic [1:0]  rst_sync_reg;
   wire         rst_n = rst_sync_reg[1];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   logic [7:0]  en_reg;
   logic [7:0]  cfg_reg;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_en_reg;
   srdc_state_e state_reg;
   srdc_state_e state_next;
   logic [15:0] period_cnt_reg;
   logic [31:0] wd_cnt_reg;
   logic [7:0]  win_cnt_reg;
   logic        win_half_reg;
   logic [7:0]  last_period_reg;
   logic [16:0] result_reg;
   logic        sysref_prev_reg;
   logic        sysref_lvl;
   logic [8:0]  samp_cnt;
   logic [8:0]  avg_phase;

   // register decode
   wire       wr_en    = wr_strobe && addr == `SRDC_ADDR_ENABLE;
   wire       wr_cfg   = wr_strobe && addr == `SRDC_ADDR_CONFIG;
   wire       wr_clr   = wr_strobe && addr == `SRDC_ADDR_IRQ_CLR;
   wire       wr_ien   = wr_strobe && addr == `SRDC_ADDR_IRQ_EN;
   wire [7:0] en_next  = wr_en ? wr_data : en_reg;
   wire [7:0] cfg_next = wr_cfg ? wr_data : cfg_reg;
   wire       start    = wr_en && wr_data[`SRDC_EN_BIT] && !en_reg[`SRDC_EN_BIT];
   wire       abort    = !en_next[`SRDC_EN_BIT];
   wire       enabled  = en_reg[`SRDC_EN_BIT];

   wire [1:0] avg_code = cfg_reg[`SRDC_AVG_MSB:`SRDC_AVG_LSB];
   wire [1:0] dur_code = cfg_reg[`SRDC_DUR_MSB:`SRDC_DUR_LSB];

   // accumulation window of 4^(dur+1) cycles
   wire [8:0] win_len  = 9'(`SRDC_WIN_BASE) << {dur_code, 1'b0};
   wire [8:0] win_lm1  = win_len - 9'h001;
   wire [7:0] win_mask = win_lm1[7:0];
   wire       win_wrap = win_cnt_reg == win_mask;

   // averages 4^(avg+1)
   wire [3:0] avg_shift = 4'({avg_code, 1'b0}) + 4'(`SRDC_AVG_BASE_LOG2);
   wire [8:0] avg_target = 9'h001 << avg_shift;

   wire [15:0] period_lim = (dur_code == 2'h0) ? 16'(PERIOD_LIM0) :
                            (dur_code == 2'h1) ? 16'(PERIOD_LIM1) :
                            (dur_code == 2'h2) ? 16'(PERIOD_LIM2) :
                                                 16'(PERIOD_LIM3);
   wire        period_over = period_cnt_reg > period_lim;

   // watchdog limit grows with both codes, so a slow but legal run is not taken for a hang
   wire [3:0]  wd_exp   = 4'(avg_code) + 4'(dur_code) + 4'(`SRDC_CAL_EXP_OFS);
   wire [31:0] wd_limit = 32'(CAL_UNIT) << {wd_exp, 1'b0};
   wire        wd_over  = wd_cnt_reg >= wd_limit;

   wire sysref_rise = sysref_lvl && !sysref_prev_reg;
   wire busy        = state_reg == srdc_seek || state_reg == srdc_run;
   wire take_sample = state_reg == srdc_run && sysref_rise;
   wire samples_met = samp_cnt == avg_target;

   srdc_pin_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .pin      (sysref_pin),
      .level    (sysref_lvl)
   );

   // phase of each sysref edge inside a double window
   srdc_phase_avg #(
      .PW (9),
      .NW (9)
   ) u_avg (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .clear    (start),
      .sample   (take_sample),
      .phase    ({win_half_reg, win_cnt_reg}),
      .shift    (avg_shift),
      .count    (samp_cnt),
      .average  (avg_phase)
   );

   // sequence; disable wins over everything
   srdc_state_e fsm_next;
   always_comb begin
      fsm_next = state_reg;
      unique case (state_reg)
         srdc_idle: begin
            if (start) begin
               fsm_next = srdc_seek;
            end
         end
         srdc_seek: begin
            if (period_over || wd_over) begin
               fsm_next = srdc_fail;
            end else if (sysref_rise) begin
               fsm_next = srdc_run;
            end
         end
         srdc_run: begin
            if (samples_met) begin
               fsm_next = srdc_done;
            end else if (period_over || wd_over) begin
               fsm_next = srdc_fail;
            end
         end
         srdc_done: fsm_next = srdc_done;
         srdc_fail: fsm_next = srdc_fail;
         default:   fsm_next = srdc_idle;
      endcase
   end
   assign state_next = abort ? srdc_idle : fsm_next;

   // set wins over a clear in the same cycle, so no event is lost
   wire        done_evt     = state_reg == srdc_run && state_next == srdc_done;
   wire        fail_evt     = state_next == srdc_fail && state_reg != srdc_fail;
   wire [1:0]  irq_evt      = {fail_evt, done_evt};
   wire [1:0]  irq_clr      = wr_clr ? wr_data[1:0] : 2'h0;
   wire [1:0]  irq_en_next  = wr_ien ? wr_data[1:0] : irq_en_reg;
   wire [1:0]  irq_stat_nxt = (irq_stat_reg & ~irq_clr) | irq_evt;
   wire        irq_next     = |(irq_stat_nxt & irq_en_next);

   // inversion from window half, coarse from last period, fine from phase
   wire [16:0] result_next  = done_evt ? {avg_phase[8], last_period_reg, avg_phase[7:0]}
                                       : result_reg;
   wire [16:0] delay_next   = enabled ? result_reg : manual_delay;
   wire        done_flag    = enabled && state_reg == srdc_done;
   wire [23:0] result_word  = {6'h00, done_flag, result_reg};

   wire [23:0] rd_mux = (addr == `SRDC_ADDR_ENABLE)   ? {16'h0000, en_reg} :
                        (addr == `SRDC_ADDR_CONFIG)   ? {16'h0000, cfg_reg} :
                        (addr == `SRDC_ADDR_RESULT)   ? result_word :
                        (addr == `SRDC_ADDR_IRQ_STAT) ? {22'h000000, irq_stat_reg} :
                        (addr == `SRDC_ADDR_IRQ_EN)   ? {22'h000000, irq_en_reg} :
                                                        24'h000000;
   wire [23:0] rd_next = rd_strobe ? rd_mux : 24'h000000;

   // saturates so a missing sysref cannot wrap back under the limit
   wire [15:0] period_inc = (&period_cnt_reg) ? period_cnt_reg : period_cnt_reg + 16'h0001;
   wire [15:0] period_next = (start || sysref_rise) ? 16'h0000 :
                             busy ? period_inc : period_cnt_reg;
   wire [31:0] wd_next = start ? 32'h00000000 :
                         busy ? wd_cnt_reg + 32'h00000001 : wd_cnt_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_reg       <= `SRDC_ENABLE_RST;
         cfg_reg      <= `SRDC_CONFIG_RST;
         irq_stat_reg <= 2'h0;
         irq_en_reg   <= 2'h0;
         cal_irq      <= 1'b0;
         rd_data      <= 24'h000000;
      end else if (ce) begin
         en_reg       <= en_next;
         cfg_reg      <= cfg_next;
         irq_stat_reg <= irq_stat_nxt;
         irq_en_reg   <= irq_en_next;
         cal_irq      <= irq_next;
         rd_data      <= rd_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg       <= srdc_idle;
         period_cnt_reg  <= 16'h0000;
         wd_cnt_reg      <= 32'h00000000;
         sysref_prev_reg <= 1'b0;
         result_reg      <= 17'h00000;
         delay_ctrl      <= 17'h00000;
      end else if (ce) begin
         state_reg       <= state_next;
         period_cnt_reg  <= period_next;
         wd_cnt_reg      <= wd_next;
         sysref_prev_reg <= sysref_lvl;
         result_reg      <= result_next;
         delay_ctrl      <= delay_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_reg     <= 8'h00;
         win_half_reg    <= 1'b0;
         last_period_reg <= 8'h00;
      end else if (ce) begin
         if (start) begin
            win_cnt_reg  <= 8'h00;
            win_half_reg <= 1'b0;
         end else begin
            win_cnt_reg  <= (win_cnt_reg + 8'h01) & win_mask;
            win_half_reg <= win_half_reg ^ win_wrap;
         end
         if (take_sample) begin
            last_period_reg <= period_cnt_reg[7:0];
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_manual_follow: assert property ((ce && !enabled) |=>
      delay_ctrl == $past(manual_delay))
      else $error("delay output does not follow manual value");
   chk_auto_ignore: assert property ((ce && enabled) |=>
      delay_ctrl == $past(result_reg))
      else $error("delay output not from calibration result");
   chk_start_rise: assert property ((state_reg == srdc_idle && !(ce && start)) |=>
      state_reg == srdc_idle)
      else $error("calibration left idle without rising enable");
   chk_enable_reset: assert property ($rose(rst_n) |->
      en_reg == `SRDC_ENABLE_RST && cfg_reg == `SRDC_CONFIG_RST && !cal_irq)
      else $error("registers not at reset value");
   chk_avg_count: assert property ((state_reg == srdc_run ##1 state_reg == srdc_done) |->
      samp_cnt == avg_target)
      else $error("completion with wrong number of averages");
   chk_window_len: assert property (win_cnt_reg <= win_mask || $past(cfg_reg) != cfg_reg)
      else $error("accumulation window overran its length");
   chk_period_limit: assert property ((ce && busy && period_over && !abort) |=>
      state_reg == srdc_fail || state_reg == srdc_done)
      else $error("over-long sysref period did not fail");
   chk_cal_bound: assert property ((ce && busy && wd_over && !abort) |=> !busy)
      else $error("calibration ran past its bound");
   chk_result_ro: assert property ((state_reg != srdc_run) |=> $stable(result_reg))
      else $error("result changed outside completion");
   chk_done_read: assert property ((ce && rd_strobe && addr == `SRDC_ADDR_RESULT)
      |=> rd_data[`SRDC_DONE_BIT] == $past(done_flag) && rd_data[16:0] == $past(result_reg))
      else $error("result read does not match state");
   chk_abort_manual: assert property ((ce && wr_en && !wr_data[`SRDC_EN_BIT]) |=>
      state_reg == srdc_idle ##1 (!ce || delay_ctrl == $past(manual_delay)))
      else $error("disable did not return manual control");
   chk_irq_level: assert property (ce |=>
      cal_irq == |(irq_stat_reg & irq_en_reg))
      else $error("interrupt level does not follow enabled status");
   chk_done_sticky: assert property ((ce && done_evt) |=>
      irq_stat_reg[`SRDC_IRQ_DONE_BIT])
      else $error("completion event lost");
   chk_fail_sticky: assert property ((ce && fail_evt) |=>
      irq_stat_reg[`SRDC_IRQ_FAIL_BIT])
      else $error("failure event lost");
   chk_fail_hold: assert property ((ce && state_reg == srdc_fail && !abort) |=>
      state_reg == srdc_fail)
      else $error("failed sequence left its state while enabled");
   chk_irq_clear: assert property ((ce && irq_clr[`SRDC_IRQ_DONE_BIT] && !done_evt) |=>
      !irq_stat_reg[`SRDC_IRQ_DONE_BIT])
      else $error("status bit survived its clear");
   chk_rd_idle: assert property ((ce && !rd_strobe) |=> rd_data == 24'h000000)
      else $error("read data present without a read");
   chk_start_clear: assert property ((ce && start) |=>
      state_reg == srdc_seek && samp_cnt == 9'h000 && wd_cnt_reg == 32'h00000000)
      else $error("start did not begin a fresh sequence");
   // ce low must hold the state, enable and config registers, the delay output included
   chk_ce_freeze: assert property (!ce |=>
      $stable(state_reg) && $stable(en_reg) && $stable(cfg_reg) && $stable(delay_ctrl))
      else $error("state moved while clock enable was low");

   cov_done: cover property (state_reg == srdc_run ##1 state_reg == srdc_done);
   cov_fail: cover property (busy ##1 state_reg == srdc_fail);
   cov_abort: cover property (state_reg == srdc_run ##1 state_reg == srdc_idle);
   cov_irq: cover property ($rose(cal_irq));
   cov_freeze: cover property (!ce ##1 !ce);
endmodule

// *** tb/srdc_sysref_src.sv ***
`timescale 1ns/10ps
module srdc_sysref_src (
   input  wire logic        core_clk,   // sample clock
   input  wire logic        run,        // pulse train only while high
   input  wire logic [15:0] period,     // cycles between rising edges
   output logic             sysref      // sysref pin level
);
   logic [15:0] cnt_reg;

   // the bench keeps period under the limit of the duration code it expects to pass
   always_ff @(posedge core_clk) begin
      if (!run || cnt_reg >= period - 16'h0001) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
      // four cycles high, wide enough for the pin filter to agree
      sysref <= run && (cnt_reg < 16'h0004);
   end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`include "srdc_regs.svh"
`define CHK(name, exp, got) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("MISMATCH %s expected %h seen %h", name, exp, got); \
   end \
end
module testbench;
   localparam int unsigned CAL_UNIT = 16;
   localparam int          SR_PERIOD = 24;
   logic        core_clk;
   logic        resetn;
   logic        ce;
   logic [9:0]  addr;
   logic [7:0]  wr_data;
   logic        wr_strobe;
   logic        rd_strobe;
   logic [23:0] rd_data;
   logic [16:0] manual_delay;
   logic        sysref_pin;
   logic [16:0] delay_ctrl;
   logic        cal_irq;
   logic        sr_run;
   logic [23:0] rv;
   int          failures;
   int          checks;
   int          n;

   srdc_top #(.CAL_UNIT(CAL_UNIT), .PERIOD_LIM0(16), .PERIOD_LIM1(32),
              .PERIOD_LIM2(64), .PERIOD_LIM3(128)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .manual_delay(manual_delay), .sysref_pin(sysref_pin), .delay_ctrl(delay_ctrl),
      .cal_irq(cal_irq));

   // 24-cycle period: passes duration code 1 (32), fails code 0 (16)
   srdc_sysref_src u_src (
      .core_clk(core_clk), .run(sr_run), .period(16'(SR_PERIOD)), .sysref(sysref_pin));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge core_clk);
      wr_strobe <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, output logic [23:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge core_clk);
      rd_strobe <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic wait_irq(input int bound);
      n = 0;
      while (cal_irq !== 1'b1 && n < bound) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (cal_irq !== 1'b1) begin
         failures++;
         $display("MISMATCH cal_irq wait expected 1 seen %b", cal_irq);
         end_of_test();
      end
   endtask

   task automatic t_reset();
      rd(`SRDC_ADDR_ENABLE, rv);
      `CHK("enable reset", 24'h000000, rv)
      rd(`SRDC_ADDR_CONFIG, rv);
      `CHK("config reset", 24'h000005, rv)
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("done at reset", 1'b0, rv[17])
      rd(10'h300, rv);
      `CHK("unmapped read", 24'h000000, rv)
      `CHK("manual delay", manual_delay, delay_ctrl)
   endtask

   task automatic t_reserved();
      wr(`SRDC_ADDR_ENABLE, 8'hfe);
      rd(`SRDC_ADDR_ENABLE, rv);
      `CHK("enable storage", 24'h0000fe, rv)
      repeat (40) @(posedge core_clk);
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("no start w/o bit0", 1'b0, rv[17])
      `CHK("manual delay", manual_delay, delay_ctrl)
   endtask

   task automatic t_config();
      for (int i = 0; i < 16; i++) begin
         wr(`SRDC_ADDR_CONFIG, 8'(i));
         rd(`SRDC_ADDR_CONFIG, rv);
         `CHK("config codes", 24'(i), rv)
      end
   endtask

   task automatic t_done();
      wr(`SRDC_ADDR_IRQ_EN, 8'h01);
      // configuration goes in before the enable
      // the converter's own calibration never runs in this bench
      wr(`SRDC_ADDR_CONFIG, 8'h01);
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      wait_irq(CAL_UNIT * 64 + 4);
      `CHK("avg span", 1'b1, (n >= 4 * SR_PERIOD) && (n < 6 * SR_PERIOD))
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("done flag", 1'b1, rv[17])
      `CHK("auto delay", rv[16:0], delay_ctrl)
      manual_delay <= 17'h0a5c3;
      repeat (3) @(posedge core_clk);
      `CHK("manual ignored", rv[16:0], delay_ctrl)
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("done event", 24'h000001, rv)
      wr(`SRDC_ADDR_RESULT, 8'h00);
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("result read only", 1'b1, rv[17])
      `CHK("no restart", rv[16:0], delay_ctrl)
      wr(`SRDC_ADDR_IRQ_CLR, 8'h01);
      repeat (2) @(posedge core_clk);
      `CHK("irq cleared", 1'b0, cal_irq)
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("status cleared", 24'h000000, rv)
   endtask

   task automatic t_abort();
      wr(`SRDC_ADDR_ENABLE, 8'h00);
      repeat (2) @(posedge core_clk);
      `CHK("manual back", manual_delay, delay_ctrl)
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("done needs enable", 1'b0, rv[17])
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      repeat (5) @(posedge core_clk);
      wr(`SRDC_ADDR_ENABLE, 8'h00);
      repeat (2) @(posedge core_clk);
      `CHK("abort manual", manual_delay, delay_ctrl)
      repeat (300) @(posedge core_clk);
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("run abandoned", 24'h000000, rv)
   endtask

   task automatic t_fail();
      wr(`SRDC_ADDR_IRQ_EN, 8'h02);
      // duration code 0 cannot cover a 24-cycle period
      wr(`SRDC_ADDR_CONFIG, 8'h00);
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      wait_irq(CAL_UNIT * 16 + 4);
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("fail event", 24'h000002, rv)
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("no done on fail", 1'b0, rv[17])
      wr(`SRDC_ADDR_IRQ_EN, 8'h00);
      repeat (2) @(posedge core_clk);
      `CHK("irq masked", 1'b0, cal_irq)
      wr(`SRDC_ADDR_IRQ_CLR, 8'h02);
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("fail cleared", 24'h000000, rv)
      wr(`SRDC_ADDR_ENABLE, 8'h00);
   endtask

   // strobes with ce low must leave every register untouched
   task automatic t_freeze();
      @(posedge core_clk);
      ce <= 1'b0;
      wr(`SRDC_ADDR_CONFIG, 8'h0a);
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      @(posedge core_clk);
      ce <= 1'b1;
      rd(`SRDC_ADDR_CONFIG, rv);
      `CHK("config frozen", 24'h00000f, rv)
      rd(`SRDC_ADDR_ENABLE, rv);
      `CHK("enable frozen", 24'h0000fe, rv)
   endtask

   // run length scales with the averaging code
   task automatic t_long(input logic [7:0] cfg, input int avgs);
      wr(`SRDC_ADDR_IRQ_EN, 8'h01);
      wr(`SRDC_ADDR_CONFIG, cfg);
      wr(`SRDC_ADDR_ENABLE, 8'h01);
      wait_irq((avgs + 3) * SR_PERIOD);
      `CHK("avg span", 1'b1, (n >= avgs * SR_PERIOD) && (n < (avgs + 2) * SR_PERIOD))
      rd(`SRDC_ADDR_RESULT, rv);
      `CHK("long done flag", 1'b1, rv[17])
      rd(`SRDC_ADDR_IRQ_STAT, rv);
      `CHK("long done event", 24'h000001, rv)
      wr(`SRDC_ADDR_ENABLE, 8'h00);
      wr(`SRDC_ADDR_IRQ_CLR, 8'h01);
   endtask

   initial begin
      failures = 0;
      checks = 0;
      resetn = 1'b0;
      ce = 1'b1;
      addr = 10'h000;
      wr_data = 8'h00;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      manual_delay = 17'h1235a;
      // partner counter has no reset of its own; idle clears it first
      sr_run = 1'b0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      sr_run <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_reserved();
      t_config();
      t_freeze();
      t_done();
      t_abort();
      t_fail();
      t_long(8'h06, 16);
      t_long(8'h0b, 64);
      end_of_test();
   end
endmodule
